// [rtl/cdac_i2c_slave.v]
/*
 * Two-wire slave port of a 10-bit current-sink DAC: address match,
 * acknowledge, two-byte write into the input register with transfer
 * to the DAC register, two-byte read with clear afterwards.
 * Assumes the bus wires are resolved outside from the output enables
 * and that scl and sda come asynchronously from the pins.
 */
// Operation
// - Port works for bus clock rates up to 400 kHz.
// - After a finished read the input register clears to zero.
// - Start is data falling while clock is high.
// - After start, shift seven address bits and a direction bit.
// - Match only the upper five address bits; low two ignored.
// - On match, pull data low during the ninth clock pulse.
// - Two data bytes per transfer, each byte acknowledged.
// - Write data enters high byte first, MSB first.
// - After both bytes, input register moves into DAC register.
// - Bit 15 is software power-down, active high.
// - Bits 13 to 4 carry the ten-bit code.
// - Read returns the input register high byte first, MSB first.
// - Power-down pin forces power-down without the bus clock.
`timescale 1ns/1ps
`include "cdac_defines.vh"

module cdac_i2c_slave (
    // Clock and reset.
    input wire ref_clk,
    input wire rst_n,
    // Bus pins.
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Power-down pin.
    input wire power_down_pin,
    // Converter side.
    output reg [9:0] dac_code_field,
    output wire power_down_control,
    output reg [15:0] dac_input_shift_register
);

    // ************************************************************
    // States
    // ************************************************************
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_WR = 5'h04;
    localparam [4:0] ST_RD = 5'h08;
    localparam [4:0] ST_ACK = 5'h10;

    // Bus clock period at the 400 kHz ceiling, in ref cycles; nothing checks it.
    localparam integer BUS_CYC_MIN =
        (`CDAC_CLK_MHZ * 1000) / `CDAC_BUS_KHZ_MAX;

    // Shift, count and control state of the serial port.
    reg [2:0] scl_s_r;
    reg [2:0] sda_s_r;
    reg [4:0] state_r;
    reg [3:0] bit_r;
    reg [7:0] byte_r;
    reg [1:0] bytes_r;
    reg rd_r;
    reg sda_drv_r;
    reg ack_done_r;
    reg sw_pd_r;
    reg [7:0] rd_shift_r;

    // Two-stage synchronisers plus a history stage for edges.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
        end else begin
            scl_s_r <= {scl_s_r[1:0], scl_in};
            sda_s_r <= {sda_s_r[1:0], sda_in};
        end
    end

    // Edges and bus conditions, decoded from the synchronised copies.
    wire scl_h = scl_s_r[1];
    wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
    wire scl_fall = ~scl_s_r[1] & scl_s_r[2];
    wire start_det = scl_h & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
    wire stop_det = scl_h & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

    // The line is only ever pulled low; the pull-up gives the high level.
    assign sda_out = 1'b0;
    assign sda_oe = sda_drv_r;
    // Power-down from pin acts combinationally, no bus clock needed.
    assign power_down_control = power_down_pin | sw_pd_r;

    // Serial state machine; sampled on clock rise, driven on fall.
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            byte_r <= 8'h00;
            bytes_r <= 2'h0;
            rd_r <= 1'b0;
            sda_drv_r <= 1'b0;
            ack_done_r <= 1'b0;
            rd_shift_r <= 8'h00;
            dac_input_shift_register <= `CDAC_REG_RESET;
            dac_code_field <= 10'h000;
            sw_pd_r <= 1'b0;
        end else if (start_det) begin
            state_r <= ST_ADDR;
            bit_r <= 4'h0;
            bytes_r <= 2'h0;
            sda_drv_r <= 1'b0;
        end else if (stop_det) begin
            // Read is complete once the master stops the bus.
            if (rd_r && bytes_r == 2'h2) begin
                dac_input_shift_register <= `CDAC_REG_RESET;
            end
            state_r <= ST_IDLE;
            rd_r <= 1'b0;
            bytes_r <= 2'h0;
            sda_drv_r <= 1'b0;
        end else begin
            case (state_r)
                // Idle: keep the line released until a start arrives.
                ST_IDLE: begin
                    sda_drv_r <= 1'b0;
                end
                ST_ADDR, ST_WR: begin
                    if (scl_rise) begin
                        byte_r <= {byte_r[6:0], sda_s_r[1]};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_fall && bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        ack_done_r <= 1'b0;
                        if (state_r == ST_ADDR) begin
                            // Only the upper five address bits take part.
                            if (byte_r[7:3] == `CDAC_ADDR_UPPER) begin
                                rd_r <= byte_r[0];
                                sda_drv_r <= 1'b1;
                                state_r <= ST_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            // High byte lands in upper half first.
                            if (bytes_r == 2'h0) begin
                                dac_input_shift_register[15:8] <=
                                    byte_r;
                            end else begin
                                dac_input_shift_register[7:0] <=
                                    byte_r;
                            end
                            bytes_r <= bytes_r + 2'h1;
                            sda_drv_r <= 1'b1;
                            state_r <= ST_ACK;
                        end
                    end
                end
                ST_RD: begin
                    // Drive the data bit low when the shifted bit is zero.
                    if (scl_fall) begin
                        if (bit_r == 4'h7) begin
                            sda_drv_r <= 1'b0;
                            bit_r <= 4'h8;
                            bytes_r <= bytes_r + 2'h1;
                        end else if (bit_r == 4'h8) begin
                            sda_drv_r <= 1'b0;
                            state_r <= ST_ACK;
                            ack_done_r <= 1'b1;
                        end else begin
                            sda_drv_r <= ~rd_shift_r[6];
                            rd_shift_r <= {rd_shift_r[6:0], 1'b0};
                            bit_r <= bit_r + 4'h1;
                        end
                    end else if (scl_rise && bit_r == 4'h8 && sda_s_r[1]) begin
                        // Master did not acknowledge; release the bus.
                        state_r <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (ack_done_r) begin
                        // After master acknowledge: next read byte, or idle after the second.
                        ack_done_r <= 1'b0;
                        bit_r <= 4'h0;
                        if (bytes_r == 2'h2) begin
                            state_r <= ST_IDLE;
                        end else begin
                            rd_shift_r <= dac_input_shift_register[7:0];
                            sda_drv_r <= ~dac_input_shift_register[7];
                            state_r <= ST_RD;
                        end
                    end else if (scl_fall) begin
                        // Ninth pulse over: release, or drive the first read bit, then move on.
                        sda_drv_r <= 1'b0;
                        bit_r <= 4'h0;
                        if (rd_r) begin
                            rd_shift_r <= dac_input_shift_register[15:8];
                            sda_drv_r <=
                                ~dac_input_shift_register[15];
                            state_r <= ST_RD;
                        end else if (bytes_r == 2'h2) begin
                            // Both bytes are in: update code and power-down.
                            dac_code_field <= dac_input_shift_register[
                                `CDAC_CODE_HI:`CDAC_CODE_LO];
                            sw_pd_r <=
                                dac_input_shift_register[`CDAC_PD_BIT];
                            state_r <= ST_IDLE;
                        end else begin
                            state_r <= ST_WR;
                        end
                    end
                end
                // A stray state code goes back to waiting for a start.
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// [rtl/cdac_defines.vh]
/*
 * Constants for the two-wire slave port of the current-sink DAC.
 * Assumes it is included by its bare name from the rtl/ folder.
 */
`ifndef CDAC_DEFINES_VH
`define CDAC_DEFINES_VH

// ****************************************************************
// Address matching
// ****************************************************************
`define CDAC_ADDR_UPPER 5'h03
`define CDAC_ADDR_HI 6
`define CDAC_ADDR_LO 2

// ****************************************************************
// Input register layout and reset value
// ****************************************************************
`define CDAC_REG_RESET 16'h0000
`define CDAC_PD_BIT 15
`define CDAC_CODE_HI 13
`define CDAC_CODE_LO 4

// ****************************************************************
// Timing
// ****************************************************************
`define CDAC_CLK_MHZ 200
`define CDAC_BUS_KHZ_MAX 400

`endif

// [test/cdac_i2c_slave_sva.sv]
/* Checker for the two-wire DAC slave port, bound to its top ports.
   Assumes one clock domain, ref_clk, with rst_n synchronous low. */
`timescale 1ns/1ps
module cdac_i2c_slave_sva (
    // Clock, reset and bus pins.
    input wire ref_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    // Power-down and converter side.
    input wire power_down_pin,
    input wire [9:0] dac_code_field,
    input wire power_down_control,
    input wire [15:0] dac_input_shift_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Reset must clear both registers and release the data line.
    reset_clear_a: assert property (disable iff (1'b0)
        !rst_n |=> dac_code_field == 10'h000 && !sda_oe &&
        dac_input_shift_register == 16'h0000)
        else $error("reset left state behind");
    pd_pin_a: assert property (power_down_pin |-> power_down_control)
        else $error("pin did not force power-down");
    sw_pd_a: assert property (
        $changed(dac_code_field) && !power_down_pin |->
        power_down_control == dac_input_shift_register[15])
        else $error("software power-down not taken");
    code_xfer_a: assert property ($changed(dac_code_field) |->
        dac_code_field == dac_input_shift_register[13:4])
        else $error("code does not match input register");
    ack_setup_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled while clock high");
    ack_release_a: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("data released while clock high");
    drive_hold_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved during clock high");
    open_drain_a: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("data line driven high");
    cover property ($rose(sda_oe));
    cover property ($changed(dac_code_field));
    cover property ($fell(|dac_input_shift_register));
endmodule
bind cdac_i2c_slave cdac_i2c_slave_sva i_cdac_i2c_slave_sva (.ref_clk,
    .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .power_down_pin,
    .dac_code_field, .power_down_control, .dac_input_shift_register);

// [test/cdac_bus_master.sv]
/* Behavioural two-wire bus master at 400 kHz, four phases per bit.
   Assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/1ps
module cdac_bus_master #(parameter Q = 125) (
    // Clock and bus.
    input wire ref_clk,
    output reg scl = 1'b1,
    output reg sda_pull = 1'b0,
    input wire sda
);
    // One quarter of a 2.5 us bit keeps the rate at 400 kHz.
    task wt;
        repeat (Q) @(posedge ref_clk);
    endtask
    // Data falls while the clock is high.
    task start;
        sda_pull <= 1'b1;
        wt;
        scl <= 1'b0;
        wt;
    endtask
    // Data rises while the clock is high.
    task stop;
        sda_pull <= 1'b1;
        wt;
        scl <= 1'b1;
        wt;
        sda_pull <= 1'b0;
        wt;
    endtask
    // Data changes only in the low half of the clock.
    task bitx(input b, output r);
        sda_pull <= ~b;
        wt;
        scl <= 1'b1;
        wt;
        r = sda;
        wt;
        scl <= 1'b0;
        wt;
    endtask
    // Eight bits then the acknowledge slot; m pulls it low.
    task xfer(input [7:0] tx, input m, output [7:0] rx, output ack);
        integer i;
        reg a;
        begin
            for (i = 7; i >= 0; i = i - 1) bitx(tx[i], rx[i]);
            bitx(~m, a);
            ack = ~a;
        end
    endtask
endmodule

// [test/current_dac_i2c_slave_port_test.sv]
/* Self-checking bench for the DAC slave port.
   Assumes the bus master model drives every transfer. */
`timescale 1ns/1ps
module current_dac_i2c_slave_port_test;
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    reg pd_pin = 1'b0;
    wire scl, m_pull, sda_oe, sda_out, pdc;
    wire [9:0] code;
    wire [15:0] ireg;
    wire sda_line = ~(m_pull | (sda_oe & ~sda_out));
    integer miscompares = 0, compares = 0, cyc = 0, k;
    reg [7:0] rx;
    reg ak;
    reg [15:0] ex;
    initial forever #2.5 ref_clk = ~ref_clk;
    cdac_i2c_slave i_cdac_i2c_slave (.ref_clk(ref_clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .power_down_pin(pd_pin), .dac_code_field(code),
        .power_down_control(pdc), .dac_input_shift_register(ireg));
    cdac_bus_master i_cdac_bus_master (.ref_clk(ref_clk), .scl(scl),
        .sda_pull(m_pull), .sda(sda_line));
    task chk(input [47:0] nm, input [15:0] e, input [15:0] g); begin
        compares = compares + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    end endtask
    task xb(input [7:0] t, input m);
        i_cdac_bus_master.xfer(t, m, rx, ak);
    endtask
    task end_of_test; begin
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end endtask
    // The tests need about 76,000 cycles; a hang is cut short at 90,000.
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    // Reset, four writes over the address range, a foreign address, a read.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk("ireg", 16'h0000, ireg);
        chk("code", 16'h0000, {6'h00, code});
        @(posedge ref_clk);
        for (k = 0; k < 4; k = k + 1) begin
            ex = {k[1:0], 6'h15, k[1:0], 6'h2C};
            i_cdac_bus_master.start;
            xb({5'h03, k[1:0], 1'b0}, 1'b0);
            chk("aack", 16'h0001, {15'h0000, ak});
            xb(ex[15:8], 1'b0);
            chk("hack", 16'h0001, {15'h0000, ak});
            xb(ex[7:0], 1'b0);
            chk("lack", 16'h0001, {15'h0000, ak});
            i_cdac_bus_master.stop;
            chk("ireg", ex, ireg);
            chk("code", {6'h00, ex[13:4]}, {6'h00, code});
            chk("pd", {15'h0000, ex[15]}, {15'h0000, pdc});
            pd_pin <= 1'b1;
            @(posedge ref_clk);
            chk("pdpin", 16'h0001, {15'h0000, pdc});
            pd_pin <= 1'b0;
        end
        i_cdac_bus_master.start;
        xb(8'h20, 1'b0);
        chk("nack", 16'h0000, {15'h0000, ak});
        i_cdac_bus_master.stop;
        chk("ireg", ex, ireg);
        i_cdac_bus_master.start;
        xb(8'h1B, 1'b0);
        chk("rack", 16'h0001, {15'h0000, ak});
        xb(8'hFF, 1'b1);
        chk("rdhi", {8'h00, ex[15:8]}, {8'h00, rx});
        xb(8'hFF, 1'b0);
        chk("rdlo", {8'h00, ex[7:0]}, {8'h00, rx});
        i_cdac_bus_master.stop;
        chk("ireg", 16'h0000, ireg);
        chk("code", {6'h00, ex[13:4]}, {6'h00, code});
        end_of_test;
    end
endmodule
